// ==== design/ssw_consts.vh ====
// Constants for the dual switch controller address and power-on logic
`ifndef SSW_CONSTS_VH
`define SSW_CONSTS_VH
`define SSW_ADDR_TOP 4'hb
`define SSW_STRAP_LOW 2'h0
`define SSW_STRAP_MID 2'h1
`define SSW_STRAP_HIGH 2'h2
`define SSW_CLK_HZ 125000000
`define SSW_POR_US 300
`define SSW_DIP_US 100
`define SSW_PUMP_HZ 300000
`define SSW_BIT_CMD_FIRST 0
`define SSW_BIT_CMD_SECOND 1
`endif

// ==== design/ssw_strap_map.v ====
// Maps two three-level strap readings to the low address bits
`timescale 1ns/1ps
`include "ssw_consts.vh"
module ssw_strap_map
(
    input wire [1:0] strap_low,
    input wire [1:0] strap_high,
    output reg [2:0] addr_low,
    output reg addr_valid
);
    reg [3:0] idx;
    always @*
    begin
        idx = 4'h0;
        addr_low = 3'h0;
        addr_valid = 1'b0;
        if (strap_low != 2'h3 && strap_high != 2'h3)
        begin
            idx = {2'h0, strap_high} * 4'h3 + {2'h0, strap_low};
            if (idx != 4'h4)
            begin
                addr_valid = 1'b1;
                addr_low = (idx > 4'h4) ? idx[2:0] - 3'h1 : idx[2:0];
            end
        end
    end
endmodule // ssw_strap_map

// ==== design/ssw_switch_ctrl.v ====
// Serial slave, address straps and power-on hold for two switch drives
//
// What this block does
// - Address is 1011 plus three strap bits
// - Eight strap combinations map ascending addresses
// - Both straps mid gives no address
// - Both drives low after power-up
// - Hold operation 300 us after supply good
// - Restart hold only after 100 us dip
// - Standby stops pump when both off
// - Pump clocked near 300 kHz while on
// - Read direction ignores rest of transfer
// - Acknowledge address and command bytes
// - Latch two bits, apply at Stop
// - Start or Stop mid-byte discards data
`timescale 1ns/1ps
`include "ssw_consts.vh"
module ssw_switch_ctrl
#(
    parameter POR_CYCLES = (`SSW_CLK_HZ / 1000000) * `SSW_POR_US,
    parameter DIP_CYCLES = (`SSW_CLK_HZ / 1000000) * `SSW_DIP_US,
    parameter PUMP_HALF = `SSW_CLK_HZ / (2 * `SSW_PUMP_HZ)
)
(
    input wire ref_clk,
    input wire rst_n,
    input wire supply_good,
    input wire [1:0] addr_strap_low_pin,
    input wire [1:0] addr_strap_high_pin,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out_ff,
    output reg sda_oe_ff,
    output reg switch_drive_first,
    output reg switch_drive_second,
    output reg pump_clk_ff,
    output reg pump_run_ff,
    output reg low_supply_lockout,
    output reg ready_ff
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_AACK = 3'h2;
    localparam ST_CMD = 3'h3;
    localparam ST_CACK = 3'h4;
    localparam ST_WAIT = 3'h5;
    localparam ST_SKIP = 3'h6;

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers
    reg [1:0] scl_s_ff;
    reg [1:0] sda_s_ff;
    reg [1:0] sup_s_ff;
    reg [1:0] lo_s1_ff;
    reg [1:0] lo_s2_ff;
    reg [1:0] hi_s1_ff;
    reg [1:0] hi_s2_ff;
    reg scl_d_ff;
    reg sda_d_ff;
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_s_ff <= 2'h3;
            sda_s_ff <= 2'h3;
            sup_s_ff <= 2'h0;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            lo_s1_ff <= 2'h0;
            lo_s2_ff <= 2'h0;
            hi_s1_ff <= 2'h0;
            hi_s2_ff <= 2'h0;
        end
        else
        begin
            lo_s1_ff <= addr_strap_low_pin;
            lo_s2_ff <= lo_s1_ff;
            hi_s1_ff <= addr_strap_high_pin;
            hi_s2_ff <= hi_s1_ff;
            scl_s_ff <= {scl_s_ff[0], scl_in};
            sda_s_ff <= {sda_s_ff[0], sda_in};
            sup_s_ff <= {sup_s_ff[0], supply_good};
            scl_d_ff <= scl_s_ff[1];
            sda_d_ff <= sda_s_ff[1];
        end
    end
    wire scl = scl_s_ff[1];
    wire sda = sda_s_ff[1];
    wire supply = sup_s_ff[1];
    wire scl_rise = scl & ~scl_d_ff;
    wire scl_fall = ~scl & scl_d_ff;
    wire start_det = scl & scl_d_ff & sda_d_ff & ~sda;
    wire stop_det = scl & scl_d_ff & ~sda_d_ff & sda;

    ////////////////////////////////////////////////////////////////////////////
    // Power-on hold and lockout
    reg [31:0] por_cnt_ff;
    reg [31:0] dip_cnt_ff;
    reg hold_ff;
    reg release_ff;
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            por_cnt_ff <= 32'h0;
            dip_cnt_ff <= 32'h0;
            hold_ff <= 1'b1;
            release_ff <= 1'b0;
            low_supply_lockout <= 1'b1;
        end
        else
        begin
            release_ff <= 1'b0;
            low_supply_lockout <= ~supply;
            if (hold_ff)
            begin
                if (!supply)
                    por_cnt_ff <= 32'h0;
                else if (por_cnt_ff >= POR_CYCLES - 1)
                begin
                    hold_ff <= 1'b0;
                    release_ff <= 1'b1;
                end
                else
                    por_cnt_ff <= por_cnt_ff + 32'h1;
            end
            else
            begin
                if (supply)
                    dip_cnt_ff <= 32'h0;
                else if (dip_cnt_ff >= DIP_CYCLES - 1)
                begin
                    hold_ff <= 1'b1;
                    por_cnt_ff <= 32'h0;
                    dip_cnt_ff <= 32'h0;
                end
                else
                    dip_cnt_ff <= dip_cnt_ff + 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address capture
    wire [2:0] map_low;
    wire map_valid;
    reg [6:0] my_addr_ff;
    reg addr_ok_ff;
    ssw_strap_map u_map
    (
        .strap_low(lo_s2_ff),
        .strap_high(hi_s2_ff),
        .addr_low(map_low),
        .addr_valid(map_valid)
    );
    // Straps are synchronised too; settled long before the hold ends
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            my_addr_ff <= 7'h0;
            addr_ok_ff <= 1'b0;
        end
        else if (release_ff)
        begin
            my_addr_ff <= {`SSW_ADDR_TOP, map_low};
            addr_ok_ff <= map_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial slave
    reg [2:0] st_ff;
    reg [3:0] bit_cnt_ff;
    reg [7:0] shift_ff;
    reg [1:0] latch_ff;
    reg latch_ok_ff;
    wire [7:0] shifted = {shift_ff[6:0], sda};
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h0;
            latch_ff <= 2'h0;
            latch_ok_ff <= 1'b0;
            sda_out_ff <= 1'b1;
            sda_oe_ff <= 1'b0;
            switch_drive_first <= 1'b0;
            switch_drive_second <= 1'b0;
            ready_ff <= 1'b0;
        end
        else if (hold_ff)
        begin
            st_ff <= ST_IDLE;
            latch_ok_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            switch_drive_first <= 1'b0;
            switch_drive_second <= 1'b0;
            ready_ff <= 1'b0;
        end
        else
        begin
            ready_ff <= 1'b1;
            if (start_det)
            begin
                latch_ok_ff <= 1'b0;
                st_ff <= addr_ok_ff ? ST_ADDR : ST_SKIP;
                bit_cnt_ff <= 4'h0;
                sda_oe_ff <= 1'b0;
            end
            else if (stop_det)
            begin
                if (latch_ok_ff && st_ff == ST_WAIT)
                begin
                    switch_drive_first <= latch_ff[`SSW_BIT_CMD_FIRST];
                    switch_drive_second <= latch_ff[`SSW_BIT_CMD_SECOND];
                end
                latch_ok_ff <= 1'b0;
                st_ff <= ST_IDLE;
                sda_oe_ff <= 1'b0;
            end
            else
            begin
                case (st_ff)
                    ST_ADDR, ST_CMD:
                    begin
                        if (scl_rise)
                        begin
                            shift_ff <= shifted;
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_ff == 4'h8)
                        begin
                            bit_cnt_ff <= 4'h0;
                            if (st_ff == ST_ADDR)
                            begin
                                if (shift_ff[7:1] == my_addr_ff && !shift_ff[0])
                                begin
                                    sda_out_ff <= 1'b0;
                                    sda_oe_ff <= 1'b1;
                                    st_ff <= ST_AACK;
                                end
                                else
                                    st_ff <= ST_SKIP;
                            end
                            else
                            begin
                                sda_out_ff <= 1'b0;
                                sda_oe_ff <= 1'b1;
                                st_ff <= ST_CACK;
                                latch_ff <= shift_ff[1:0];
                                latch_ok_ff <= 1'b1;
                            end
                        end
                    end
                    ST_AACK, ST_CACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_oe_ff <= 1'b0;
                            st_ff <= (st_ff == ST_AACK) ? ST_CMD : ST_WAIT;
                        end
                    end
                    // Extra bytes after the command are not acknowledged
                    ST_WAIT, ST_SKIP, ST_IDLE:
                        sda_oe_ff <= 1'b0;
                    default:
                        st_ff <= ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Charge pump clock
    reg [15:0] pump_cnt_ff;
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pump_cnt_ff <= 16'h0;
            pump_clk_ff <= 1'b0;
            pump_run_ff <= 1'b0;
        end
        else
        begin
            pump_run_ff <= switch_drive_first | switch_drive_second;
            if (!pump_run_ff)
            begin
                pump_cnt_ff <= 16'h0;
                pump_clk_ff <= 1'b0;
            end
            else if (pump_cnt_ff >= PUMP_HALF[15:0] - 16'h1)
            begin
                pump_cnt_ff <= 16'h0;
                pump_clk_ff <= ~pump_clk_ff;
            end
            else
                pump_cnt_ff <= pump_cnt_ff + 16'h1;
        end
    end
endmodule // ssw_switch_ctrl

// ==== dv/ssw_host_model.sv ====
// Host model: drives the serial clock and the open-drain data wire
`timescale 1ns/1ps
module ssw_host_model
(
    input wire ref_clk,
    output reg scl_in,
    output wire sda_in,
    input wire sda_out_ff,
    input wire sda_oe_ff
);
reg sda_drv;
// Pull-up wins unless a party pulls low
assign sda_in = sda_drv & ~(sda_oe_ff & ~sda_out_ff);
initial
begin
    scl_in = 1'b1;
    sda_drv = 1'b1;
end
// Half of the 160 ns link clock
task half;
    repeat (10) @(negedge ref_clk);
endtask
// Send Byte framing
// Data released before the clock rises, so a repeated Start is clean
task start;
    begin
        sda_drv = 1'b1;
        half;
        scl_in = 1'b1;
        half;
        sda_drv = 1'b0;
        half;
        scl_in = 1'b0;
        half;
    end
endtask
task stop;
    begin
        sda_drv = 1'b0;
        half;
        scl_in = 1'b1;
        half;
        sda_drv = 1'b1;
        half;
    end
endtask
// MSB first; fewer than 8 bits leaves the byte cut short
task xfer(input [7:0] b, input integer n, output ack);
    integer i;
    begin
        ack = 1'b0;
        for (i = 7; i > 7 - n; i = i - 1)
        begin
            sda_drv = b[i];
            half;
            scl_in = 1'b1;
            half;
            scl_in = 1'b0;
            repeat (3) @(negedge ref_clk);
        end
        if (n == 8)
        begin
            sda_drv = 1'b1;
            half;
            scl_in = 1'b1;
            ack = ~sda_in;
            half;
            scl_in = 1'b0;
            repeat (3) @(negedge ref_clk);
        end
    end
endtask
endmodule // ssw_host_model

// ==== dv/ssw_switch_ctrl_assertions.sv ====
// Port-level checks for the switch controller
`timescale 1ns/1ps
module ssw_switch_ctrl_assertions
(
    input wire ref_clk,
    input wire rst_n,
    input wire supply_good,
    input wire [1:0] addr_strap_low_pin,
    input wire [1:0] addr_strap_high_pin,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out_ff,
    input wire sda_oe_ff,
    input wire switch_drive_first,
    input wire switch_drive_second,
    input wire pump_clk_ff,
    input wire pump_run_ff,
    input wire low_supply_lockout,
    input wire ready_ff
);
reg sda_q_ff;
reg [3:0] stop_age_ff;
wire any_on = switch_drive_first || switch_drive_second;
// Cycles since a Stop on the pins, saturating
always @(posedge ref_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        sda_q_ff <= 1'b1;
        stop_age_ff <= 4'hf;
    end
    else
    begin
        sda_q_ff <= sda_in;
        if (scl_in && sda_in && !sda_q_ff)
            stop_age_ff <= 4'h0;
        else if (stop_age_ff != 4'hf)
            stop_age_ff <= stop_age_ff + 4'h1;
    end
end
default clocking dcb @(posedge ref_clk); endclocking
default disable iff (!rst_n);
sequence ack_hold;
    sda_oe_ff [*8];
endsequence
sequence pump_idle;
    !pump_run_ff [*3];
endsequence
a_drives_in_hold: assert property (!ready_ff ##1 !ready_ff |-> !any_on)
    else $error("drive on during hold");
a_hold_long: assert property ($rose(ready_ff) |-> !$past(low_supply_lockout, 40))
    else $error("hold released early");
a_dip_long: assert property ($fell(ready_ff) |-> $past(low_supply_lockout, 8))
    else $error("short dip restarted hold");
a_pump_on: assert property (any_on |=> pump_run_ff)
    else $error("pump idle with drive on");
a_pump_off: assert property (!any_on |=> !pump_run_ff)
    else $error("pump runs in standby");
a_pump_frozen: assert property (pump_idle |-> $stable(pump_clk_ff))
    else $error("pump clock toggles in standby");
a_pump_half: assert property (pump_run_ff && $changed(pump_clk_ff) |=>
    (!pump_run_ff || $stable(pump_clk_ff)) [*3]) else $error("pump half period short");
a_ack_low: assert property (sda_oe_ff |-> ready_ff && !sda_out_ff)
    else $error("bad ack drive");
a_ack_stands: assert property ($rose(sda_oe_ff) |-> ack_hold)
    else $error("ack too short");
a_drive_at_stop: assert property (ready_ff && $past(ready_ff) &&
    ($changed(switch_drive_first) || $changed(switch_drive_second)) |-> stop_age_ff <= 4'h8)
    else $error("drive changed without Stop");
endmodule // ssw_switch_ctrl_assertions
bind ssw_switch_ctrl ssw_switch_ctrl_assertions u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .supply_good(supply_good), .addr_strap_low_pin(addr_strap_low_pin),
    .addr_strap_high_pin(addr_strap_high_pin), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff), .switch_drive_first(switch_drive_first),
    .switch_drive_second(switch_drive_second), .pump_clk_ff(pump_clk_ff),
    .pump_run_ff(pump_run_ff), .low_supply_lockout(low_supply_lockout), .ready_ff(ready_ff));

// ==== dv/ssw_switch_ctrl_test.sv ====
// Self-checking bench for the switch controller
`timescale 1ns/1ps
`include "ssw_consts.vh"
module ssw_switch_ctrl_test;
reg ref_clk;
reg rst_n;
reg supply_good;
reg [1:0] strap_lo;
reg [1:0] strap_hi;
reg [1:0] cur;
reg [7:0] adr;
reg [7:0] cmd;
reg ak;
wire scl_in, sda_in, sda_out_ff, sda_oe_ff, drv_a, drv_b, pclk, prun, lock, ready_ff;
integer err_count, samples_checked, seed, hi, lo;
ssw_switch_ctrl #(.POR_CYCLES(50), .DIP_CYCLES(20), .PUMP_HALF(4)) dut (.ref_clk(ref_clk),
    .rst_n(rst_n), .supply_good(supply_good), .addr_strap_low_pin(strap_lo),
    .addr_strap_high_pin(strap_hi), .scl_in(scl_in), .sda_in(sda_in), .sda_out_ff(sda_out_ff),
    .sda_oe_ff(sda_oe_ff), .switch_drive_first(drv_a), .switch_drive_second(drv_b),
    .pump_clk_ff(pclk), .pump_run_ff(prun), .low_supply_lockout(lock), .ready_ff(ready_ff));
ssw_host_model host (.ref_clk(ref_clk), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff));
// Seven-bit address for a strap pair; 8'hff where no address exists
function [7:0] exp_addr(input integer h, input integer l);
    integer idx;
    begin
        idx = h * 3 + l;
        exp_addr = {1'b0, `SSW_ADDR_TOP, 3'h0} + idx[7:0] - ((idx > 4) ? 8'h01 : 8'h00);
        if (idx == 4)
            exp_addr = 8'hff;
    end
endfunction
task check(input [7:0] got, input [7:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
endtask
task send(input [7:0] a, input [7:0] c, input ok);
    begin
        host.start;
        host.xfer(a, 8, ak);
        check({7'h0, ak}, {7'h0, ok});
        host.xfer(c, 8, ak);
        check({7'h0, ak}, {7'h0, ok});
        check({6'h0, drv_b, drv_a}, {6'h0, cur});
        host.stop;
        repeat (8) @(negedge ref_clk);
        if (ok)
            cur = c[1:0];
        check({6'h0, drv_b, drv_a}, {6'h0, cur});
        check({7'h0, prun}, {7'h0, |cur});
    end
endtask
// Dips shorter than the filter must leave operation alone
task power(input integer n);
    integer k;
    begin
        supply_good = 1'b0;
        repeat (n) @(negedge ref_clk);
        supply_good = 1'b1;
        repeat (30) @(negedge ref_clk);
        check({7'h0, ready_ff}, (n > 10) ? 8'h00 : 8'h01);
        for (k = 0; k < 200 && ready_ff !== 1'b1; k = k + 1)
            @(negedge ref_clk);
        if (n > 10)
            cur = 2'h0;
        check({7'h0, ready_ff}, 8'h01);
        check({6'h0, drv_b, drv_a}, {6'h0, cur});
    end
endtask
task final_report;
    begin
        $display("Checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
endtask
initial
begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
end
initial
begin
    #400000;
    err_count = err_count + 1;
    final_report;
end
////////////////////////////////////////////////////////////////////////////////
initial
begin
    seed = 42;
    err_count = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    supply_good = 1'b1;
    strap_lo = 2'h0;
    strap_hi = 2'h0;
    cur = 2'h0;
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    for (hi = 0; hi < 3; hi = hi + 1)
        for (lo = 0; lo < 3; lo = lo + 1)
        begin
            strap_hi = hi[1:0];
            strap_lo = lo[1:0];
            power(40);
            adr = exp_addr(hi, lo);
            cmd = $random(seed);
            if (adr == 8'hff)
                send({`SSW_ADDR_TOP, 3'h4, 1'b0}, cmd, 1'b0);
            else
            begin
                send({adr[6:0] ^ (7'h01 << (cmd[5:3] % 3'h7)), 1'b0}, cmd, 1'b0);
                send({adr[6:0], 1'b1}, cmd, 1'b0);
                send({adr[6:0], 1'b0}, cmd, 1'b1);
            end
        end
    // Straps now invalid, but the address stays until the next hold
    strap_hi = 2'h1;
    strap_lo = 2'h1;
    send({adr[6:0], 1'b0}, 8'h03, 1'b1);
    power(10);
    host.start;
    host.xfer({adr[6:0], 1'b0}, 8, ak);
    host.xfer(8'h00, 4, ak);
    host.stop;
    repeat (8) @(negedge ref_clk);
    check({6'h0, drv_b, drv_a}, {6'h0, cur});
    host.start;
    host.xfer({adr[6:0], 1'b0}, 8, ak);
    host.xfer(8'h00, 5, ak);
    send({adr[6:0], 1'b0}, 8'h02, 1'b1);
    final_report;
end
endmodule // ssw_switch_ctrl_test
